/* File: hw/iop_pkg.sv */
package iop_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int NCH = 4;
  localparam int TW  = 16;
  localparam int NPT = 8;
  localparam int AW  = 8;
  localparam int DW  = 32;

  // ****************************************************************
  // Register offsets (word addresses)
  // ****************************************************************
  localparam logic [AW-1:0] OFF_CFG   = 8'h00;
  localparam logic [AW-1:0] OFF_ODLY  = 8'h04;
  localparam logic [AW-1:0] OFF_XSH   = 8'h08;
  localparam logic [AW-1:0] OFF_YSH   = 8'h0c;
  localparam logic [AW-1:0] OFF_STAT  = 8'h10;
  localparam logic [AW-1:0] OFF_SHORT = 8'h14;
  localparam logic [AW-1:0] OFF_LONG  = 8'h15;
  localparam logic [AW-1:0] OFF_DLY   = 8'h18;
  localparam logic [AW-1:0] OFF_CURVE = 8'h20;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_SEL_LSB  = 4;
  localparam int CURVE_Y_LSB  = 16;
  localparam int STAT_TI_LSB  = 16;

  // ****************************************************************
  // Selection codes and reset values
  // ****************************************************************
  localparam logic [1:0] SEL_OFF   = 2'h0;
  localparam logic [1:0] SEL_SHORT = 2'h1;
  localparam logic [1:0] SEL_LONG  = 2'h2;

  localparam int CLK_NS       = 8;
  localparam int SHORT_DLY_NS = 20000;
  localparam int LONG_DLY_NS  = 30000;
  localparam int SHORT_DLY_CYC = (SHORT_DLY_NS + CLK_NS - 1) / CLK_NS;
  localparam int LONG_DLY_CYC  = (LONG_DLY_NS + CLK_NS - 1) / CLK_NS;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    IOP_CONTROLLED,
    IOP_CLOSING,
    IOP_PASSIVE
  } iop_mode_t;

  typedef enum logic [1:0] {
    CH_IDLE,
    CH_OPEN
  } iop_ch_st_t;

  typedef enum logic [1:0] {
    SC_IDLE,
    SC_RUN
  } iop_sc_st_t;

endpackage

/* File: hw/iop_curve_mem.sv */
`timescale 1ns/10ps
module iop_curve_mem #(
  parameter int W = 32,
  parameter int D = 8,
  parameter int A = $clog2(D)
) (
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  input  wire logic         we_i,
  input  wire logic [A-1:0] waddr_i,
  input  wire logic [W-1:0] wdata_i,
  input  wire logic [A-1:0] raddr_i,
  output logic      [W-1:0] rdata_o
);

  logic [W-1:0] mem [D];

  // ****************************************************************
  // Storage and registered read
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= mem[raddr_i];
    end
  end

endmodule

/* File: hw/iop_pulse_gen.sv */
// What this block does
// - Opening pulse output is low while open
// - Controlled mode: voltage four rise starts opening
// - Falling edge at start event plus edge delay
// - Last voltage one fall marks end control
// - Delay is curve(ti plus x shift) plus y
// - Rising edge at end control plus delay
// - Curve editable; shifts updated at run time
// - Feature fires with rising edge delay
// - Per channel mode select, own channel only
// - Select 0 off, 1 short, 2 long
// - Closing mode: rise at feature, else limit two
// - Closing feature static delay after limit one
// - Passive: no feature, limits three and two
// - Controlled disabled: rise at voltage one fall
//
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/10ps
module iop_pulse_gen
  import iop_pkg::*;
#(
  parameter int N = NCH
) (
  input  wire logic          clk_i,
  input  wire logic          rstn_i,
  input  wire logic [N-1:0]  voltage_limit_four_i,
  input  wire logic [N-1:0]  voltage_limit_one_i,
  input  wire logic [N-1:0]  current_limit_one_i,
  input  wire logic [N-1:0]  current_limit_two_i,
  input  wire logic [N-1:0]  current_limit_three_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [DW-1:0] wdata_i,
  input  wire logic          wr_i,
  input  wire logic          rd_i,
  output logic      [DW-1:0] rdata_o,
  output logic      [N-1:0]  open_pulse_n_o,
  output logic      [N-1:0]  feature_o
);

  localparam int PA = $clog2(NPT);
  localparam int CW = $clog2(N);
  localparam logic [TW-1:0] TMAX = {TW{1'b1}};

  // ****************************************************************
  // Decode helpers
  // ****************************************************************
  function automatic logic hit(input logic [AW-1:0] a,
                               input logic [AW-1:0] base,
                               input int            n);
    hit = (a >= base) && ({1'b0, a} < ({1'b0, base} + (AW+1)'(n)));
  endfunction

  function automatic logic [CW-1:0] idx(input logic [AW-1:0] a,
                                        input logic [AW-1:0] base);
    logic [AW-1:0] d;
    d   = a - base;
    idx = d[CW-1:0];
  endfunction

  function automatic logic [TW-1:0] inc_sat(input logic [TW-1:0] v);
    inc_sat = (v == TMAX) ? v : v + 1'b1;
  endfunction

  // ****************************************************************
  // Software registers
  // ****************************************************************
  logic [1:0]    mode_ff  [N];
  logic [1:0]    sel_ff   [N];
  logic [TW-1:0] odly_ff  [N];
  logic [TW-1:0] xsh_ff   [N];
  logic [TW-1:0] ysh_ff   [N];
  logic [TW-1:0] short_ff;
  logic [TW-1:0] long_ff;

  logic [TW-1:0] ti_w     [N];
  logic [7:0]    stat_w   [N];
  logic [N-1:0]  start_w;
  logic [N-1:0]  req_set_w;
  logic [TW-1:0] dly_ff   [N];
  logic [N-1:0]  dly_ok_ff;

  logic          mem_we;
  logic [DW-1:0] mem_rdata;
  logic [PA-1:0] sc_addr_ff;

  // Shifts take effect at the next delay computation
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int c = 0; c < N; c++) begin
        mode_ff[c] <= 2'h0;
        sel_ff[c]  <= 2'h0;
        odly_ff[c] <= '0;
        xsh_ff[c]  <= '0;
        ysh_ff[c]  <= '0;
      end
      short_ff <= TW'(SHORT_DLY_CYC);
      long_ff  <= TW'(LONG_DLY_CYC);
    end else if (wr_i) begin
      if (hit(addr_i, OFF_CFG, N)) begin
        mode_ff[idx(addr_i, OFF_CFG)] <= wdata_i[CFG_MODE_LSB +: 2];
        sel_ff[idx(addr_i, OFF_CFG)]  <= wdata_i[CFG_SEL_LSB +: 2];
      end
      if (hit(addr_i, OFF_ODLY, N)) begin
        odly_ff[idx(addr_i, OFF_ODLY)] <= wdata_i[TW-1:0];
      end
      if (hit(addr_i, OFF_XSH, N)) begin
        xsh_ff[idx(addr_i, OFF_XSH)] <= wdata_i[TW-1:0];
      end
      if (hit(addr_i, OFF_YSH, N)) begin
        ysh_ff[idx(addr_i, OFF_YSH)] <= wdata_i[TW-1:0];
      end
      if (addr_i == OFF_SHORT) begin
        short_ff <= wdata_i[TW-1:0];
      end
      if (addr_i == OFF_LONG) begin
        long_ff <= wdata_i[TW-1:0];
      end
    end
  end

  // Curve points: x in low half, y in high half, x ascending
  assign mem_we = wr_i && hit(addr_i, OFF_CURVE, NPT);

  iop_curve_mem #(
    .W (DW),
    .D (NPT)
  ) u_curve (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .we_i    (mem_we),
    .waddr_i (PA'(addr_i - OFF_CURVE)),
    .wdata_i (wdata_i),
    .raddr_i (sc_addr_ff),
    .rdata_o (mem_rdata)
  );

  // ****************************************************************
  // Register read
  // ****************************************************************
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= '0;
      if (rd_i) begin
        if (hit(addr_i, OFF_CFG, N)) begin
          rdata_o[CFG_MODE_LSB +: 2] <= mode_ff[idx(addr_i, OFF_CFG)];
          rdata_o[CFG_SEL_LSB +: 2]  <= sel_ff[idx(addr_i, OFF_CFG)];
        end
        if (hit(addr_i, OFF_ODLY, N)) begin
          rdata_o[TW-1:0] <= odly_ff[idx(addr_i, OFF_ODLY)];
        end
        if (hit(addr_i, OFF_XSH, N)) begin
          rdata_o[TW-1:0] <= xsh_ff[idx(addr_i, OFF_XSH)];
        end
        if (hit(addr_i, OFF_YSH, N)) begin
          rdata_o[TW-1:0] <= ysh_ff[idx(addr_i, OFF_YSH)];
        end
        if (hit(addr_i, OFF_STAT, N)) begin
          rdata_o[7:0] <= stat_w[idx(addr_i, OFF_STAT)];
          rdata_o[STAT_TI_LSB +: TW] <= ti_w[idx(addr_i, OFF_STAT)];
        end
        if (hit(addr_i, OFF_DLY, N)) begin
          rdata_o[TW-1:0] <= dly_ff[idx(addr_i, OFF_DLY)];
        end
        if (addr_i == OFF_SHORT) begin
          rdata_o[TW-1:0] <= short_ff;
        end
        if (addr_i == OFF_LONG) begin
          rdata_o[TW-1:0] <= long_ff;
        end
      end
    end
  end

  // ****************************************************************
  // Shared closing delay evaluation
  // ****************************************************************
  iop_sc_st_t        sc_st_ff;
  logic [CW-1:0]     sc_ch_ff;
  logic [N-1:0]      req_ff;
  logic signed [TW+1:0] sc_xq_ff;
  logic [TW-1:0]     sc_y_ff;
  logic              sc_rv_ff;
  logic [PA-1:0]     sc_idx_ff;
  logic [TW-1:0]     pt_x;
  logic [TW-1:0]     pt_y;
  logic [TW-1:0]     y_now;
  logic signed [TW+1:0] dsum;
  logic [TW-1:0]     dclamp;
  logic [CW-1:0]     pick;
  logic              sc_done;

  assign pt_x    = mem_rdata[TW-1:0];
  assign pt_y    = mem_rdata[CURVE_Y_LSB +: TW];
  assign sc_done = sc_rv_ff && (sc_idx_ff == PA'(NPT-1));

  // Step curve: y of the last point whose x does not exceed the input; y of point 0 if none does
  always_comb begin
    y_now = sc_y_ff;
    if (sc_rv_ff && ((sc_idx_ff == '0) ||
        ($signed({2'b00, pt_x}) <= sc_xq_ff))) begin
      y_now = pt_y;
    end
    dsum = $signed({2'b00, y_now})
         + $signed({{2{ysh_ff[sc_ch_ff][TW-1]}}, ysh_ff[sc_ch_ff]});
    if (dsum < 0) begin
      dclamp = '0;
    end else if (dsum > $signed({2'b00, TMAX})) begin
      dclamp = TMAX;
    end else begin
      dclamp = dsum[TW-1:0];
    end
    pick = '0;
    for (int c = N - 1; c >= 0; c--) begin
      if (req_ff[c]) begin
        pick = CW'(c);
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sc_st_ff   <= SC_IDLE;
      sc_ch_ff   <= '0;
      sc_xq_ff   <= '0;
      sc_y_ff    <= '0;
      sc_rv_ff   <= 1'b0;
      sc_idx_ff  <= '0;
      sc_addr_ff <= '0;
    end else begin
      sc_rv_ff  <= (sc_st_ff == SC_RUN) && !sc_done;
      sc_idx_ff <= sc_addr_ff;
      sc_y_ff   <= y_now;
      unique case (sc_st_ff)
        SC_IDLE: begin
          if (|req_ff) begin
            sc_st_ff   <= SC_RUN;
            sc_ch_ff   <= pick;
            sc_xq_ff   <= $signed({2'b00, ti_w[pick]})
                        + $signed({{2{xsh_ff[pick][TW-1]}}, xsh_ff[pick]});
            sc_addr_ff <= '0;
          end
        end
        SC_RUN: begin
          if (sc_addr_ff != PA'(NPT-1)) begin
            sc_addr_ff <= sc_addr_ff + 1'b1;
          end
          if (sc_done) begin
            sc_st_ff <= SC_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      req_ff <= '0;
    end else begin
      for (int c = 0; c < N; c++) begin
        if (req_set_w[c]) begin
          req_ff[c] <= 1'b1;
        end else if (sc_st_ff == SC_IDLE && |req_ff && pick == CW'(c)) begin
          req_ff[c] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dly_ok_ff <= '0;
      for (int c = 0; c < N; c++) begin
        dly_ff[c] <= '0;
      end
    end else begin
      for (int c = 0; c < N; c++) begin
        if (start_w[c]) begin
          dly_ok_ff[c] <= 1'b0;
        end else if (sc_done && sc_ch_ff == CW'(c)) begin
          dly_ff[c]    <= dclamp;
          dly_ok_ff[c] <= 1'b1;
        end
      end
    end
  end

  // ****************************************************************
  // Per channel pulse sequencing
  // ****************************************************************
  for (genvar g = 0; g < N; g++) begin : g_ch
    iop_ch_st_t    st_ff;
    iop_mode_t     md;
    logic [TW-1:0] t_open_ff;
    logic [TW-1:0] t_close_ff;
    logic [TW-1:0] ti_ff;
    logic [TW-1:0] sdly;
    logic          fell_ff;
    logic          eoc_ff;
    logic          open_n_ff;
    logic          feat_ff;
    logic          rise;
    logic          feat;
    logic          ena;

    always_comb begin
      unique case (mode_ff[g])
        2'h0:    md = IOP_CONTROLLED;
        2'h1:    md = IOP_CLOSING;
        default: md = IOP_PASSIVE;
      endcase
    end

    assign ena  = (sel_ff[g] == SEL_SHORT) || (sel_ff[g] == SEL_LONG);
    assign sdly = (sel_ff[g] == SEL_LONG) ? long_ff : short_ff;
    assign start_w[g] = (md == IOP_PASSIVE) ? current_limit_three_i[g]
                                            : voltage_limit_four_i[g];
    assign req_set_w[g] = (st_ff == CH_OPEN) && !start_w[g]
                       && (md == IOP_CONTROLLED) && ena
                       && current_limit_one_i[g];

    always_comb begin
      rise = 1'b0;
      feat = 1'b0;
      if (st_ff == CH_OPEN && !start_w[g]) begin
        unique case (md)
          IOP_CONTROLLED: begin
            if (!ena) begin
              rise = voltage_limit_one_i[g];
            end else begin
              rise = eoc_ff && dly_ok_ff[g] && !voltage_limit_one_i[g]
                  && (t_close_ff >= dly_ff[g]);
              feat = rise;
            end
          end
          IOP_CLOSING: begin
            if (ena) begin
              rise = eoc_ff && (t_close_ff >= sdly);
              feat = rise;
            end else begin
              rise = current_limit_two_i[g];
            end
          end
          IOP_PASSIVE: begin
            rise = current_limit_two_i[g];
          end
        endcase
      end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        st_ff      <= CH_IDLE;
        t_open_ff  <= '0;
        t_close_ff <= '0;
        ti_ff      <= '0;
        fell_ff    <= 1'b0;
        eoc_ff     <= 1'b0;
      end else begin
        t_open_ff  <= inc_sat(t_open_ff);
        t_close_ff <= inc_sat(t_close_ff);
        if (start_w[g]) begin
          st_ff     <= CH_OPEN;
          t_open_ff <= '0;
          fell_ff   <= 1'b0;
          eoc_ff    <= 1'b0;
        end else if (st_ff == CH_OPEN) begin
          if (!fell_ff && t_open_ff >= odly_ff[g]) begin
            fell_ff <= 1'b1;
          end
          if (md == IOP_CONTROLLED && current_limit_one_i[g]) begin
            ti_ff <= t_open_ff;
          end
          if (md == IOP_CONTROLLED && voltage_limit_one_i[g]) begin
            eoc_ff     <= 1'b1;
            t_close_ff <= '0;
          end
          if (md == IOP_CLOSING && current_limit_one_i[g]) begin
            eoc_ff     <= 1'b1;
            t_close_ff <= '0;
          end
          if (rise) begin
            st_ff <= CH_IDLE;
          end
        end
      end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        open_n_ff <= 1'b1;
        feat_ff   <= 1'b0;
      end else begin
        feat_ff <= feat && (md != IOP_PASSIVE);
        if (start_w[g] || rise) begin
          open_n_ff <= 1'b1;
        end else if (st_ff == CH_OPEN && !fell_ff
                     && t_open_ff >= odly_ff[g]) begin
          open_n_ff <= 1'b0;
        end
      end
    end

    assign ti_w[g]           = ti_ff;
    assign open_pulse_n_o[g] = open_n_ff;
    assign feature_o[g]      = feat_ff;
    assign stat_w[g] = {3'h0, (st_ff == CH_OPEN), dly_ok_ff[g], eoc_ff,
                        fell_ff, open_n_ff};
  end

endmodule

/* File: tb/iop_pulse_chk.sv */
`timescale 1ns/10ps
module iop_pulse_chk
  import iop_pkg::*;
#(
  parameter int N = NCH
) (
  input wire logic          clk_i,
  input wire logic          rstn_i,
  input wire logic [N-1:0]  voltage_limit_four_i,
  input wire logic [N-1:0]  voltage_limit_one_i,
  input wire logic [N-1:0]  current_limit_two_i,
  input wire logic [N-1:0]  current_limit_three_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic          wr_i,
  input wire logic          rd_i,
  input wire logic [DW-1:0] rdata_o,
  input wire logic [N-1:0]  open_pulse_n_o,
  input wire logic [N-1:0]  feature_o
);
  // ****************************************************************
  // Shadow of mode, select and zero edge delay per channel
  // ****************************************************************
  logic [1:0]   mode_ff [N];
  logic [1:0]   sel_ff  [N];
  logic [N-1:0] odz_ff;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      odz_ff  <= '1;
      mode_ff <= '{default: 2'h0};
      sel_ff  <= '{default: 2'h0};
    end else if (wr_i) begin
      for (int i = 0; i < N; i++) begin
        if (addr_i == OFF_CFG + AW'(i)) begin
          mode_ff[i] <= wdata_i[CFG_MODE_LSB +: 2];
          sel_ff[i]  <= wdata_i[CFG_SEL_LSB +: 2];
        end
        if (addr_i == OFF_ODLY + AW'(i)) begin
          odz_ff[i] <= (wdata_i[15:0] == 16'h0);
        end
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  // ****************************************************************
  // Assertions
  // ****************************************************************
  AST_RST_IDLE: assert property (
    $rose(rstn_i) |-> (&open_pulse_n_o) && (feature_o == '0))
    else $error("outputs not idle after reset");
  AST_FEAT_EDGE: assert property (
    (feature_o & ~(open_pulse_n_o & ~$past(open_pulse_n_o))) == '0)
    else $error("feature without rising pulse edge");
  AST_FEAT_ONE: assert property (
    (|feature_o) |=> (feature_o & $past(feature_o)) == '0)
    else $error("feature longer than one cycle");
  AST_RD_IDLE: assert property (
    !$past(rd_i) |-> rdata_o == '0)
    else $error("read data outside read cycle");

  for (genvar g = 0; g < N; g++) begin : g_ch
    logic psv;
    logic off;
    assign psv = mode_ff[g][1];
    assign off = (sel_ff[g] == 2'h0) || (sel_ff[g] == 2'h3);
    AST_START_FALL: assert property (
      ((psv ? current_limit_three_i[g] : voltage_limit_four_i[g])
       && odz_ff[g]) |-> ##2 !open_pulse_n_o[g])
      else $error("pulse did not fall after start");
    AST_PASS_RISE: assert property (
      (psv && !open_pulse_n_o[g] && current_limit_two_i[g])
      |=> open_pulse_n_o[g])
      else $error("passive pulse did not rise");
    AST_CLOS_OFF: assert property (
      (mode_ff[g] == 2'h1 && off && !open_pulse_n_o[g]
       && current_limit_two_i[g]) |=> open_pulse_n_o[g])
      else $error("closing mode off did not rise");
    AST_CTRL_OFF: assert property (
      (mode_ff[g] == 2'h0 && off && !open_pulse_n_o[g]
       && voltage_limit_one_i[g]) |=> open_pulse_n_o[g])
      else $error("controlled mode off did not rise");
    AST_NO_FEAT: assert property (
      (psv || off) |-> !feature_o[g])
      else $error("feature while disabled");
  end
endmodule

bind iop_pulse_gen iop_pulse_chk #(.N(N)) u_chk (
  .clk_i(clk_i), .rstn_i(rstn_i),
  .voltage_limit_four_i(voltage_limit_four_i),
  .voltage_limit_one_i(voltage_limit_one_i),
  .current_limit_two_i(current_limit_two_i),
  .current_limit_three_i(current_limit_three_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .open_pulse_n_o(open_pulse_n_o),
  .feature_o(feature_o)
);

/* File: tb/iop_timing_model.sv */
`timescale 1ns/10ps
module iop_timing_model
  import iop_pkg::*;
(
  input wire logic           clk_i,
  input wire logic           rstn_i,
  input wire logic [NCH-1:0] open_pulse_n_i,
  input wire logic [NCH-1:0] feature_i
);
  // ****************************************************************
  // Edge time stamps and low interval per channel
  // ****************************************************************
  int             cyc;
  int             fall_at  [NCH];
  int             rise_at  [NCH];
  int             low_len  [NCH];
  int             feat_cnt [NCH];
  logic [NCH-1:0] prev_ff;

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cyc      <= 0;
      prev_ff  <= '1;
      fall_at  <= '{default: 0};
      rise_at  <= '{default: 0};
      low_len  <= '{default: 0};
      feat_cnt <= '{default: 0};
    end else begin
      cyc     <= cyc + 1;
      prev_ff <= open_pulse_n_i;
      for (int i = 0; i < NCH; i++) begin
        if (prev_ff[i] && !open_pulse_n_i[i]) begin
          fall_at[i] <= cyc;
        end
        if (!prev_ff[i] && open_pulse_n_i[i]) begin
          rise_at[i] <= cyc;
          low_len[i] <= cyc - fall_at[i];
        end
        if (feature_i[i]) begin
          feat_cnt[i] <= feat_cnt[i] + 1;
        end
      end
    end
  end
endmodule

/* File: tb/testbench.sv */
`timescale 1ns/10ps
module testbench
  import iop_pkg::*;
();
  localparam int EV4 = 0;
  localparam int EV1 = 1;
  localparam int EC1 = 2;
  localparam int EC2 = 3;
  localparam int EC3 = 4;

  logic          clk_i;
  logic          rstn_i;
  logic [3:0]    ev_q [5];
  logic [AW-1:0] addr_i;
  logic [DW-1:0] wdata_i;
  logic          wr_i;
  logic          rd_i;
  logic [DW-1:0] rdata_o;
  logic [3:0]    open_pulse_n_o;
  logic [3:0]    feature_o;
  int            err_total = 0;
  int            cmp_count = 0;
  int            tcyc = 0;
  int            t1;
  int            t2;
  int            fc;

  iop_pulse_gen uut (
    .clk_i(clk_i), .rstn_i(rstn_i),
    .voltage_limit_four_i(ev_q[EV4]), .voltage_limit_one_i(ev_q[EV1]),
    .current_limit_one_i(ev_q[EC1]), .current_limit_two_i(ev_q[EC2]),
    .current_limit_three_i(ev_q[EC3]),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .open_pulse_n_o(open_pulse_n_o),
    .feature_o(feature_o)
  );

  iop_timing_model tu (
    .clk_i(clk_i), .rstn_i(rstn_i),
    .open_pulse_n_i(open_pulse_n_o), .feature_i(feature_o)
  );

  // ****************************************************************
  // Access and check tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input int got, input int lo, input int hi);
    chk(32'(got), (got >= lo && got <= hi) ? 32'(got) : 32'(lo));
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd_chk(input logic [AW-1:0] a, input logic [DW-1:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, e);
  endtask

  // One-cycle event; t is the partner's count at the sampling edge
  task automatic ev(input int k, input int c, output int t);
    @(posedge clk_i);
    ev_q[k][c] <= 1'b1;
    @(posedge clk_i);
    t = tu.cyc;
    ev_q[k][c] <= 1'b0;
  endtask

  task automatic wait_rise(input int c);
    int k;
    k = 0;
    while (open_pulse_n_o[c] !== 1'b1 && k < 400) begin
      @(posedge clk_i);
      k++;
    end
    @(posedge clk_i);
  endtask

  task automatic wrap_up;
    if (err_total == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    tcyc <= tcyc + 1;
    if (tcyc == 5000) begin
      err_total++;
      wrap_up;
    end
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    rstn_i  = 1'b0;
    ev_q    = '{default: 4'h0};
    addr_i  = '0;
    wdata_i = '0;
    wr_i    = 1'b0;
    rd_i    = 1'b0;
    repeat (8) @(posedge clk_i);
    rstn_i <= 1'b1;
    rd_chk(OFF_SHORT, 32'h9c4);
    rd_chk(OFF_LONG, 32'hea6);
    rd_chk(8'h30, 32'h0);
    wr(OFF_CURVE, 32'h1234_5678);
    rd_chk(OFF_CURVE, 32'h0);
    wr(OFF_CFG + 8'h1, 32'h2);
    rd_chk(OFF_CFG + 8'h1, 32'h2);
    // Passive channel with edge delay
    wr(OFF_ODLY + 8'h1, 32'h3);
    ev(EC3, 1, t1);
    repeat (20) @(posedge clk_i);
    ev(EC2, 1, t2);
    wait_rise(1);
    chk_rng(tu.low_len[1], t2 - t1 - 6, t2 - t1 - 3);
    chk(32'(tu.feat_cnt[1]), 32'h0);
    // Closing mode: select off, short, long
    wr(OFF_SHORT, 32'h28);
    wr(OFF_LONG, 32'h3c);
    for (int s = 0; s < 3; s++) begin
      wr(OFF_CFG, 32'h1 | (32'(s) << CFG_SEL_LSB));
      fc = tu.feat_cnt[0];
      ev(EV4, 0, t1);
      repeat (4) @(posedge clk_i);
      ev(EC1, 0, t1);
      ev(EC2, 0, t2);
      wait_rise(0);
      if (s == 0) begin
        t1 = t2;
      end
      t2 = (s == 0) ? 0 : 20 + 20 * s;
      chk_rng(tu.rise_at[0] - t1, t2, t2 + 4);
      chk(32'(tu.feat_cnt[0] - fc), (s == 0) ? 32'h0 : 32'h1);
    end
    // Controlled mode with curve and run-time shifts
    for (int i = 0; i < NPT; i++) begin
      wr(OFF_CURVE + AW'(i), {16'(40 + 10 * i), 16'(10 * i)});
    end
    wr(OFF_CFG + 8'h2, 32'h10);
    wr(OFF_YSH + 8'h2, 32'h5);
    for (int r = 0; r < 2; r++) begin
      wr(OFF_XSH + 8'h2, (r == 0) ? 32'ha : 32'h0);
      ev(EV4, 2, t1);
      repeat (33) @(posedge clk_i);
      ev(EC1, 2, t1);
      ev(EV1, 2, t2);
      repeat (5) @(posedge clk_i);
      ev(EV1, 2, t2);
      wait_rise(2);
      fc = (r == 0) ? 85 : 75;
      chk_rng(tu.rise_at[2] - t2, fc, fc + 4);
      chk(32'(tu.feat_cnt[2]), 32'(r + 1));
      rd_chk(OFF_DLY + 8'h2, (r == 0) ? 32'h55 : 32'h4b);
    end
    // Controlled mode disabled by the unused select code
    wr(OFF_CFG + 8'h3, 32'h30);
    ev(EV4, 3, t1);
    repeat (3) @(posedge clk_i);
    ev(EV1, 3, t2);
    wait_rise(3);
    chk_rng(tu.rise_at[3] - t2, 0, 3);
    chk(32'(tu.feat_cnt[3]), 32'h0);
    chk(32'(open_pulse_n_o), 32'hf);
    wrap_up;
  end
endmodule
